// *** src/dsr_pkg.sv ***
// Constants and types shared by the serial format router.
package dsr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  DSR_FMT_OFS   = 8'h4e;
  localparam logic [7:0]  DSR_CTRL_OFS  = 8'h48;
  localparam logic [7:0]  DSR_FMT_RST   = 8'h00;
  localparam logic        DSR_POL_RST   = 1'b0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          DSR_TX_SRC_HI = 7;
  localparam int          DSR_TX_SRC_LO = 6;
  localparam int          DSR_TX_LEN    = 5;
  localparam int          DSR_TX_ST     = 4;
  localparam int          DSR_RX_TGT_HI = 3;
  localparam int          DSR_RX_TGT_LO = 2;
  localparam int          DSR_RX_LEN    = 1;
  localparam int          DSR_RX_ST     = 0;
  localparam int          DSR_CTRL_POL  = 3;

  // ----------------------------------------------------------------------
  // Word lengths and codes
  // ----------------------------------------------------------------------
  localparam logic [4:0]  DSR_LEN16     = 5'h10;
  localparam logic [4:0]  DSR_LEN8      = 5'h08;
  localparam logic [15:0] DSR_ZERO_CODE = 16'h0000;

  typedef enum logic [1:0] {DSR_TX_ZERO, DSR_TX_FIFO, DSR_TX_LEFT, DSR_TX_RIGHT} dsr_tx_src_t;
  typedef enum logic [1:0] {DSR_RX_NONE, DSR_RX_FIFO, DSR_RX_DAC, DSR_RX_FM} dsr_rx_tgt_t;

endpackage

// *** src/dsr_router.sv ***
// Serial port format, source and target router for an external signal processor.
`timescale 1ns/1ps
// Summary of operation
// - Format bits 7-6 pick the transmit feed: 00 zero code, 01 FIFO, 10 left or stereo A/D, 11 right A/D.
// - With no transmit source the transmit word is the zero code, so zeros go out on every request.
// - Format bit 5 makes transmitted words 16 bits when set and 8 bits when clear, both unsigned.
// - Format bit 4 makes transmission from source 10 stereo, left word first then right word, and mono when clear.
// - Format bits 3-2 route received words: 00 nowhere, 01 FIFO, 10 D/A pair, 11 FM D/A pair.
// - With no receive target the received word is held at the zero code whatever arrives on the data pin.
// - Mono words for the D/A pair go unchanged to the right channel and complemented to the left.
// - Mono words for the FM D/A pair go unchanged to the right FM channel and complemented to the left.
// - Format bit 1 makes received words 16 bits when set and 8 bits when clear, both unsigned.
// - Format bit 0 makes reception stereo, taking words alternately as left then right, and mono when clear.
// - A transmit frame sync asks the device to shift one 8-bit or 16-bit word out on the transmit pin.
// - A receive frame sync marks the start of one 8-bit or 16-bit word on the receive pin.
// - The transmit pin is driven only while a word is shifting out and floats otherwise.
// - Control bit 3 makes both frame syncs active low when set and active high when clear.
module dsr_router
  import dsr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [15:0] tx_fifo_data_in,
  input  wire logic        tx_fifo_valid_in,
  output logic             tx_fifo_ready_out,
  input  wire logic [15:0] adc_left_in,
  input  wire logic [15:0] adc_right_in,
  output logic      [15:0] rx_fifo_data_out,
  output logic             rx_fifo_valid_out,
  input  wire logic        rx_fifo_ready_in,
  output logic      [15:0] dac_left_out,
  output logic      [15:0] dac_right_out,
  output logic      [15:0] fm_left_out,
  output logic      [15:0] fm_right_out,
  input  wire logic        serial_bit_clock_in,
  input  wire logic        serial_mode_enable_in,
  input  wire logic        transmit_frame_sync_in,
  input  wire logic        receive_frame_sync_in,
  input  wire logic        serial_rx_in,
  output logic             serial_tx_out,
  output logic             serial_tx_oe_out,
  output logic             rx_drop_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two and at least 2");
  end

  // ----------------------------------------------------------------------
  // State of the register side, clocked by clk_in
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                 fmt;
    logic                       pol;
    logic [7:0]                 rdata;
    logic                       tx_busy;
    logic                       tx_req;
    logic [15:0]                tx_word;
    logic                       tx_right;
    logic                       tx_rdy;
    logic [1:0]                 tx_ack_s;
    logic                       tx_ack_seen;
    logic [1:0]                 rx_req_s;
    logic                       rx_ack;
    logic [DEPTH-1:0][15:0]     mem;
    logic [AW-1:0]              wr_ptr;
    logic [AW-1:0]              rd_ptr;
    logic [AW:0]                cnt;
    logic [15:0]                out_data;
    logic                       out_vld;
    logic [15:0]                dac_l;
    logic [15:0]                dac_r;
    logic [15:0]                fm_l;
    logic [15:0]                fm_r;
  } dsr_sys_t;

  // ----------------------------------------------------------------------
  // State of the link side, clocked by serial_bit_clock_in
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [8:0]                 cfg_s1;
    logic [8:0]                 cfg_s2;
    logic                       en;
    logic                       fsx_prev;
    logic                       fsr_prev;
    logic [1:0]                 tx_req_s;
    logic                       tx_req_seen;
    logic [15:0]                tx_hold;
    logic                       tx_full;
    logic                       tx_ack;
    logic                       tx_chan;
    logic [15:0]                tx_sh;
    logic [4:0]                 tx_cnt;
    logic                       tx_out;
    logic                       tx_oe;
    logic [15:0]                rx_sh;
    logic [4:0]                 rx_cnt;
    logic                       rx_chan;
    logic [15:0]                rx_word;
    logic                       rx_right;
    logic                       rx_req;
    logic [1:0]                 rx_ack_s;
    logic                       rx_drop;
  } dsr_link_t;

  dsr_sys_t  s_r;
  dsr_sys_t  s_nxt;
  dsr_link_t l_r;
  dsr_link_t l_nxt;

  function automatic logic [4:0] dsr_len(input logic long_word);
    dsr_len = long_word ? DSR_LEN16 : DSR_LEN8;
  endfunction

  // ----------------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------------
  always_comb begin
    dsr_tx_src_t src;
    dsr_rx_tgt_t tgt;
    logic        push;
    logic        pop;
    s_nxt = s_r;
    src   = dsr_tx_src_t'(s_r.fmt[DSR_TX_SRC_HI:DSR_TX_SRC_LO]);
    tgt   = dsr_rx_tgt_t'(s_r.fmt[DSR_RX_TGT_HI:DSR_RX_TGT_LO]);
    push  = 1'b0;
    pop   = s_r.out_vld && rx_fifo_ready_in;

    if (reg_wr_in && reg_addr_in == DSR_FMT_OFS) begin
      s_nxt.fmt      = reg_wdata_in;
      s_nxt.tx_right = 1'b0;
    end
    if (reg_wr_in && reg_addr_in == DSR_CTRL_OFS) begin
      s_nxt.pol = reg_wdata_in[DSR_CTRL_POL];
    end
    if (reg_rd_in) begin
      if (reg_addr_in == DSR_FMT_OFS) begin
        s_nxt.rdata = s_r.fmt;
      end else if (reg_addr_in == DSR_CTRL_OFS) begin
        s_nxt.rdata = 8'h00;
        s_nxt.rdata[DSR_CTRL_POL] = s_r.pol;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    // Transmit feed: one word is handed to the link domain per toggle.
    s_nxt.tx_ack_s = {s_r.tx_ack_s[0], l_r.tx_ack};
    if (s_r.tx_ack_s[1] != s_r.tx_ack_seen) begin
      s_nxt.tx_ack_seen = s_r.tx_ack_s[1];
      s_nxt.tx_busy     = 1'b0;
    end
    if (!s_r.tx_busy) begin
      case (src)
        DSR_TX_ZERO: begin
          s_nxt.tx_word = DSR_ZERO_CODE;
          s_nxt.tx_req  = ~s_r.tx_req;
          s_nxt.tx_busy = 1'b1;
        end
        DSR_TX_FIFO: begin
          if (s_r.tx_rdy && tx_fifo_valid_in) begin
            s_nxt.tx_word = tx_fifo_data_in;
            s_nxt.tx_req  = ~s_r.tx_req;
            s_nxt.tx_busy = 1'b1;
          end
        end
        DSR_TX_LEFT: begin
          if (s_r.fmt[DSR_TX_ST] && s_r.tx_right) begin
            s_nxt.tx_word = adc_right_in;
          end else begin
            s_nxt.tx_word = adc_left_in;
          end
          s_nxt.tx_right = s_r.fmt[DSR_TX_ST] && !s_r.tx_right;
          s_nxt.tx_req   = ~s_r.tx_req;
          s_nxt.tx_busy  = 1'b1;
        end
        DSR_TX_RIGHT: begin
          s_nxt.tx_word = adc_right_in;
          s_nxt.tx_req  = ~s_r.tx_req;
          s_nxt.tx_busy = 1'b1;
        end
        default: begin
          s_nxt.tx_busy = s_r.tx_busy;
        end
      endcase
    end
    s_nxt.tx_rdy = !s_nxt.tx_busy && src == DSR_TX_FIFO;

    // Received words: the FIFO target waits for buffer room, which stalls the link handshake.
    s_nxt.rx_req_s = {s_r.rx_req_s[0], l_r.rx_req};
    if (s_r.rx_req_s[1] != s_r.rx_ack) begin
      case (tgt)
        DSR_RX_FIFO: begin
          if (s_r.cnt != (AW + 1)'(DEPTH) || pop) begin
            push         = 1'b1;
            s_nxt.rx_ack = s_r.rx_req_s[1];
          end
        end
        DSR_RX_DAC: begin
          if (!s_r.fmt[DSR_RX_ST]) begin
            s_nxt.dac_r = l_r.rx_word;
            s_nxt.dac_l = ~l_r.rx_word;
          end else if (l_r.rx_right) begin
            s_nxt.dac_r = l_r.rx_word;
          end else begin
            s_nxt.dac_l = l_r.rx_word;
          end
          s_nxt.rx_ack = s_r.rx_req_s[1];
        end
        DSR_RX_FM: begin
          if (!s_r.fmt[DSR_RX_ST]) begin
            s_nxt.fm_r = l_r.rx_word;
            s_nxt.fm_l = ~l_r.rx_word;
          end else if (l_r.rx_right) begin
            s_nxt.fm_r = l_r.rx_word;
          end else begin
            s_nxt.fm_l = l_r.rx_word;
          end
          s_nxt.rx_ack = s_r.rx_req_s[1];
        end
        default: begin
          s_nxt.rx_ack = s_r.rx_req_s[1];
        end
      endcase
    end

    // DEPTH-entry buffer (two entries by default) toward the receive FIFO consumer.
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = l_r.rx_word;
      s_nxt.wr_ptr          = s_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    s_nxt.out_data = s_nxt.mem[s_nxt.rd_ptr];
    s_nxt.out_vld  = s_nxt.cnt != '0;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_r     <= '0;
      s_r.fmt <= DSR_FMT_RST;
      s_r.pol <= DSR_POL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------------
  always_comb begin
    logic       pol;
    logic       fsx_act;
    logic       fsr_act;
    logic [7:0] fmt;
    logic [15:0] word;
    logic [15:0] rx_full;
    l_nxt   = l_r;
    fmt     = l_r.cfg_s2[7:0];
    pol     = l_r.cfg_s2[8];
    fsx_act = transmit_frame_sync_in ^ pol;
    fsr_act = receive_frame_sync_in ^ pol;
    word    = DSR_ZERO_CODE;
    rx_full = {l_r.rx_sh[14:0], serial_rx_in};

    // Format settings change only while the link is idle, so a plain two-stage capture suffices.
    l_nxt.cfg_s1   = {s_r.pol, s_r.fmt};
    l_nxt.cfg_s2   = l_r.cfg_s1;
    l_nxt.tx_req_s = {l_r.tx_req_s[0], s_r.tx_req};
    l_nxt.rx_ack_s = {l_r.rx_ack_s[0], s_r.rx_ack};
    l_nxt.en       = serial_mode_enable_in;
    l_nxt.fsx_prev = fsx_act;
    l_nxt.fsr_prev = fsr_act;
    l_nxt.rx_drop  = 1'b0;

    if (l_r.tx_cnt != 5'h00) begin
      l_nxt.tx_out = l_r.tx_sh[15];
      l_nxt.tx_oe  = 1'b1;
      l_nxt.tx_sh  = {l_r.tx_sh[14:0], 1'b0};
      l_nxt.tx_cnt = l_r.tx_cnt - 5'h01;
    end else begin
      l_nxt.tx_oe  = 1'b0;
      l_nxt.tx_out = 1'b0;
    end

    if (l_r.rx_cnt != 5'h00) begin
      l_nxt.rx_sh  = rx_full;
      l_nxt.rx_cnt = l_r.rx_cnt - 5'h01;
      if (l_r.rx_cnt == 5'h01) begin
        l_nxt.rx_chan = fmt[DSR_RX_ST] && !l_r.rx_chan;
        if (l_r.rx_req == l_r.rx_ack_s[1]) begin
          if (fmt[DSR_RX_TGT_HI:DSR_RX_TGT_LO] == DSR_RX_NONE) begin
            l_nxt.rx_word = DSR_ZERO_CODE;
          end else if (fmt[DSR_RX_LEN]) begin
            l_nxt.rx_word = rx_full;
          end else begin
            l_nxt.rx_word = {8'h00, rx_full[7:0]};
          end
          l_nxt.rx_right = l_r.rx_chan;
          l_nxt.rx_req   = ~l_r.rx_req;
        end else begin
          l_nxt.rx_drop = 1'b1;
        end
      end
    end

    // The word handed over by the register side waits here for the next transmit request.
    if (l_r.en && fsx_act && !l_r.fsx_prev) begin
      if (l_r.tx_full && fmt[DSR_TX_SRC_HI:DSR_TX_SRC_LO] != DSR_TX_ZERO) begin
        word = l_r.tx_hold;
      end
      l_nxt.tx_sh   = fmt[DSR_TX_LEN] ? word : {word[7:0], 8'h00};
      l_nxt.tx_cnt  = dsr_len(fmt[DSR_TX_LEN]);
      l_nxt.tx_full = 1'b0;
      l_nxt.tx_ack  = ~l_r.tx_ack;
      l_nxt.tx_chan = fmt[DSR_TX_ST] && !l_r.tx_chan;
    end
    if (l_r.tx_req_s[1] != l_r.tx_req_seen) begin
      l_nxt.tx_req_seen = l_r.tx_req_s[1];
      l_nxt.tx_hold     = s_r.tx_word;
      l_nxt.tx_full     = 1'b1;
    end

    if (l_r.en && fsr_act && !l_r.fsr_prev) begin
      l_nxt.rx_cnt = dsr_len(fmt[DSR_RX_LEN]);
      l_nxt.rx_sh  = 16'h0000;
    end

    // Enable is held past the last bit by the processor, so dropping it only ends idle frames.
    if (!l_r.en) begin
      l_nxt.tx_cnt  = 5'h00;
      l_nxt.rx_cnt  = 5'h00;
      l_nxt.tx_oe   = 1'b0;
      l_nxt.tx_chan = 1'b0;
      l_nxt.rx_chan = 1'b0;
    end
  end

  always_ff @(posedge serial_bit_clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_out     = s_r.rdata;
  assign tx_fifo_ready_out = s_r.tx_rdy;
  assign rx_fifo_data_out  = s_r.out_data;
  assign rx_fifo_valid_out = s_r.out_vld;
  assign dac_left_out      = s_r.dac_l;
  assign dac_right_out     = s_r.dac_r;
  assign fm_left_out       = s_r.fm_l;
  assign fm_right_out      = s_r.fm_r;
  assign serial_tx_out     = l_r.tx_out;
  assign serial_tx_oe_out  = l_r.tx_oe;
  assign rx_drop_out       = l_r.rx_drop;

endmodule

// *** test/dsr_router_monitor.sv ***
// Assertion checker for the serial format router ports.
`timescale 1ns/1ps
module dsr_router_monitor (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic [15:0] dac_left_out,
  input wire logic [15:0] dac_right_out,
  input wire logic [15:0] fm_left_out,
  input wire logic [15:0] fm_right_out,
  input wire logic        serial_bit_clock_in,
  input wire logic        serial_mode_enable_in,
  input wire logic        transmit_frame_sync_in,
  input wire logic        serial_tx_out,
  input wire logic        serial_tx_oe_out
);
  logic [7:0] fmt_r;
  logic       pol_r;
  logic       en_r;
  logic       act_r;
  logic       start;

  // Mirror of the format and polarity settings.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt_r <= 8'h00;
      pol_r <= 1'h0;
    end else if (reg_wr_in && reg_addr_in == 8'h4e) begin
      fmt_r <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == 8'h48) begin
      pol_r <= reg_wdata_in[3];
    end
  end

  always_ff @(posedge serial_bit_clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_r  <= 1'h0;
      act_r <= 1'h0;
    end else begin
      en_r  <= serial_mode_enable_in;
      act_r <= transmit_frame_sync_in ^ pol_r;
    end
  end
  assign start = en_r && (transmit_frame_sync_in ^ pol_r) && !act_r;

  tx_frame_len_a: assert property (@(posedge serial_bit_clock_in) disable iff (!nrst_in)
    start |-> ##2 serial_tx_oe_out [*8]) else $error("transmit enable not held for a word");
  tx_no_early_a: assert property (@(posedge serial_bit_clock_in) disable iff (!nrst_in)
    start && !serial_tx_oe_out |=> !serial_tx_oe_out) else $error("transmit enabled too early");
  tx_zero_code_a: assert property (@(posedge serial_bit_clock_in) disable iff (!nrst_in)
    fmt_r[7:6] == 2'h0 && serial_tx_oe_out |-> !serial_tx_out) else $error("nonzero bit with no source");
  tx_idle_float_a: assert property (@(posedge serial_bit_clock_in) disable iff (!nrst_in)
    !serial_mode_enable_in [*3] |-> !serial_tx_oe_out) else $error("transmit driven while idle");
  fmt_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reg_rd_in && reg_addr_in == 8'h4e |=> reg_rdata_out == $past(fmt_r)) else $error("format readback wrong");
  pol_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    reg_rd_in && reg_addr_in == 8'h48 |=> reg_rdata_out == {4'h0, $past(pol_r), 3'h0})
    else $error("control readback wrong");
  dac_mono_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fmt_r[3:2] == 2'h2 && !fmt_r[0] && $changed(dac_right_out) |-> dac_left_out == ~dac_right_out)
    else $error("mono left not complement");
  fm_mono_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fmt_r[3:2] == 2'h3 && !fmt_r[0] && $changed(fm_right_out) |-> fm_left_out == ~fm_right_out)
    else $error("mono fm left not complement");
endmodule

// *** test/dsr_dsp_model.sv ***
// Behavioural external signal processor driving the serial link.
`timescale 1ns/1ps
module dsr_dsp_model (
  input  wire logic raw_clk_in,
  input  wire logic pol_in,
  input  wire logic dx_in,
  output logic      bclk_out,
  output logic      en_out,
  output logic      fsx_out,
  output logic      fsr_out,
  output logic      dr_out
);
  logic run;
  logic fx;
  logic fr;

  // The bit clock runs for six clocks at start-up and otherwise only while a session is open.
  assign bclk_out = run & raw_clk_in;
  assign fsx_out  = fx ^ pol_in;
  assign fsr_out  = fr ^ pol_in;

  initial begin
    run    = 1'h1;
    en_out = 1'h0;
    fx     = 1'h0;
    fr     = 1'h0;
    dr_out = 1'h0;
    repeat (6) @(negedge raw_clk_in);
    run = 1'h0;
  end

  // One session of two frames; each sync lasts two bit clocks.
  task xfer(input logic tx, input int n, input logic [15:0] w0, w1, output logic [15:0] g0, g1);
    logic [15:0] w [2];
    logic [15:0] g [2];
    w[0] = w0;
    w[1] = w1;
    @(negedge raw_clk_in);
    run    = 1'h1;
    en_out = 1'h1;
    repeat (3) @(negedge raw_clk_in);
    for (int f = 0; f < 2; f++) begin
      g[f] = 16'h0000;
      fx   = tx;
      fr   = !tx;
      for (int i = 0; i <= n; i++) begin
        @(negedge raw_clk_in);
        if (i > 0) begin
          fx   = 1'h0;
          fr   = 1'h0;
          g[f] = {g[f][14:0], dx_in};
        end
        dr_out = (!tx && i < n) ? w[f][n-1-i] : 1'h0;
      end
      @(negedge raw_clk_in);
    end
    repeat (2) @(negedge raw_clk_in);
    en_out = 1'h0;
    repeat (4) @(negedge raw_clk_in);
    run = 1'h0;
    g0  = g[0];
    g1  = g[1];
  endtask
endmodule

// *** test/dsr_router_tb.sv ***
// Self-checking bench for the serial format router.
`timescale 1ns/1ps
module dsr_router_tb;
  logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
  logic        reg_wr_in = 1'h0, reg_rd_in = 1'h0, tx_fifo_valid_in = 1'h0, rx_fifo_ready_in = 1'h0;
  logic [15:0] tx_fifo_data_in = 16'h9e71, adc_left_in = 16'h5a3c, adc_right_in = 16'hc3a5;
  logic [15:0] rx_fifo_data_out, dac_left_out, dac_right_out, fm_left_out, fm_right_out, g0, g1;
  logic        clk_in = 1'h0, nrst_in = 1'h0, bclk_raw = 1'h0, pol = 1'h0, dx;
  logic        tx_fifo_ready_out, rx_fifo_valid_out, rx_drop_out, serial_tx_out, serial_tx_oe_out;
  logic        serial_bit_clock_in, serial_mode_enable_in, transmit_frame_sync_in;
  logic        receive_frame_sync_in, serial_rx_in;
  int          err_total = 0;
  int          cmp_count = 0;

  always #2.5 clk_in = ~clk_in;
  always #15 bclk_raw = ~bclk_raw;
  assign dx = serial_tx_oe_out ? serial_tx_out : 1'hz;

  dsr_router u_dsr_router (.*);
  dsr_dsp_model u_dsr_dsp_model (.raw_clk_in(bclk_raw), .pol_in(pol), .dx_in(dx), .bclk_out(serial_bit_clock_in),
    .en_out(serial_mode_enable_in), .fsx_out(transmit_frame_sync_in), .fsr_out(receive_frame_sync_in),
    .dr_out(serial_rx_in));

  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wreg(input logic [7:0] a, d);
    @(negedge clk_in);
    reg_addr_in  = a;
    reg_wdata_in = d;
    reg_wr_in    = 1'h1;
    @(negedge clk_in);
    reg_wr_in = 1'h0;
  endtask

  task automatic rreg(input logic [7:0] a, exp);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in   = 1'h1;
    @(negedge clk_in);
    reg_rd_in = 1'h0;
    chk("register read", {8'h00, reg_rdata_out}, {8'h00, exp});
  endtask

  // Second session is judged, so a word fetched under the old format is flushed.
  task automatic tx_case(input logic [7:0] f, input int n, input logic [15:0] e0, e1);
    wreg(8'h4e, f);
    repeat (2) u_dsr_dsp_model.xfer(1'h1, n, 16'h0000, 16'h0000, g0, g1);
    chk("tx first word", g0, e0);
    chk("tx second word", g1, e1);
  endtask

  task automatic rx_case(input logic [7:0] f, input int n, input logic [15:0] w0, w1);
    wreg(8'h4e, f);
    u_dsr_dsp_model.xfer(1'h0, n, w0, w1, g0, g1);
  endtask

  task automatic t_regs;
    rreg(8'h4e, 8'h00);
    rreg(8'h48, 8'h00);
    wreg(8'h4e, 8'ha5);
    rreg(8'h4e, 8'ha5);
    wreg(8'h48, 8'hff);
    rreg(8'h48, 8'h08);
    wreg(8'h40, 8'hff);
    rreg(8'h40, 8'h00);
    wreg(8'h48, 8'h00);
    $display("register test done");
  endtask

  task automatic t_tx;
    tx_case(8'h20, 16, 16'h0000, 16'h0000);
    tx_case(8'ha0, 16, 16'h5a3c, 16'h5a3c);
    tx_case(8'hc0, 8, 16'h00a5, 16'h00a5);
    // One word is prefetched under the old format, so the judged session opens on the right word.
    tx_case(8'hb0, 16, 16'hc3a5, 16'h5a3c);
    tx_fifo_valid_in = 1'h1;
    tx_case(8'h60, 16, 16'h9e71, 16'h9e71);
    wreg(8'h48, 8'h08);
    pol = 1'h1;
    tx_case(8'he0, 16, 16'hc3a5, 16'hc3a5);
    wreg(8'h48, 8'h00);
    pol = 1'h0;
    $display("transmit test done");
  endtask

  task automatic t_rx;
    rx_case(8'h0a, 16, 16'h1234, 16'h1234);
    chk("dac right", dac_right_out, 16'h1234);
    chk("dac left", dac_left_out, 16'hedcb);
    rx_case(8'h0c, 8, 16'h009c, 16'h009c);
    chk("fm right", fm_right_out, 16'h009c);
    chk("fm left", fm_left_out, 16'hff63);
    rx_case(8'h0b, 16, 16'hbeef, 16'h4d21);
    chk("dac stereo left", dac_left_out, 16'hbeef);
    chk("dac stereo right", dac_right_out, 16'h4d21);
    rx_case(8'h02, 16, 16'hffff, 16'hffff);
    chk("no target fifo", {15'h0000, rx_fifo_valid_out}, 16'h0000);
    chk("no target dac", dac_right_out, 16'h4d21);
    rx_case(8'h06, 16, 16'h0f1e, 16'h2d3c);
    chk("fifo head", rx_fifo_data_out, 16'h0f1e);
    rx_fifo_ready_in = 1'h1;
    @(negedge clk_in);
    chk("fifo next", rx_fifo_data_out, 16'h2d3c);
    chk("fifo still valid", {15'h0000, rx_fifo_valid_out}, 16'h0001);
    @(negedge clk_in);
    rx_fifo_ready_in = 1'h0;
    chk("fifo drained", {15'h0000, rx_fifo_valid_out}, 16'h0000);
    $display("receive test done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk_in);
    nrst_in = 1'h1;
    t_regs;
    t_tx;
    t_rx;
    print_verdict;
  end
endmodule

bind dsr_router dsr_router_monitor u_dsr_router_monitor (.*);
